// *** hdl/gedm_axil.sv ***
`default_nettype none
`include "gedm_cfg.svh"
module gedm_axil (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	input  wire gedm_pkg::gedm_addr_t awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire gedm_pkg::gedm_addr_t araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	output logic                      wr_en,
	output gedm_pkg::gedm_addr_t      wr_addr,
	output logic [31:0]               wr_data,
	output logic [3:0]                wr_strb,
	output logic                      rd_en,
	output gedm_pkg::gedm_addr_t      rd_addr,
	input  wire logic [31:0]          rd_data,
	input  wire logic                 rd_err,
	input  wire logic                 wr_err
);
	import gedm_pkg::*;
	logic aw_held;
	logic w_held;

	assign awready = ce && !aw_held && !bvalid;
	assign wready  = ce && !w_held && !bvalid;
	assign wr_en   = ce && aw_held && w_held && !bvalid;
	assign arready = ce && !rvalid;
	assign rd_en   = arvalid && arready;
	assign rd_addr = araddr;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= `GEDM_RESP_OK;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held  <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_err ? `GEDM_RESP_SLVERR : `GEDM_RESP_OK;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `GEDM_RESP_OK;
		end else if (ce) begin
			if (rd_en) begin
				rvalid <= 1'b1;
				rdata  <= rd_data;
				rresp  <= rd_err ? `GEDM_RESP_SLVERR : `GEDM_RESP_OK;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule : gedm_axil
`default_nettype wire

// *** hdl/gedm_cfg.svh ***
`ifndef GEDM_CFG_SVH
`define GEDM_CFG_SVH
`define GEDM_A_DISARM     8'h00
`define GEDM_A_DMA_MODE   8'h04
`define GEDM_A_IN_MODE    8'h08
`define GEDM_A_IN_COUNT   8'h0c
`define GEDM_A_BOARD      8'h10
`define GEDM_A_CONTROL    8'h14
`define GEDM_A_COMPLETION 8'h18
`define GEDM_A_STATUS     8'h1c
`define GEDM_A_EVENTS     8'h20
`define GEDM_A_DATA       8'h24
`define GEDM_MODE_AUTO    0
`define GEDM_MODE_DEM     1
`define GEDM_MODE_SIN     2
`define GEDM_IN_DMA       0
`define GEDM_IN_CONT      1
`define GEDM_CTL_START    0
`define GEDM_CTL_STOP     1
`define GEDM_CTL_TMO_OFF  2
`define GEDM_DISARM_RST   9'h000
`define GEDM_DMA_MODE_RST 3'h4
`define GEDM_CC_OK        8'h00
`define GEDM_CC_BOARD     8'h01
`define GEDM_CC_MODE      8'h02
`define GEDM_CC_BUSY      8'h03
`define GEDM_RESP_OK      2'h0
`define GEDM_RESP_SLVERR  2'h2
`endif

// *** hdl/gedm_pack.sv ***
`default_nettype none
module gedm_pack (
	input  wire logic            mclk,
	input  wire logic            rst_n,
	input  wire logic            ce,
	input  wire logic            in_valid,
	input  wire logic [7:0]      in_byte,
	output logic                 in_ready,
	input  wire logic            flush,
	output logic                 out_valid,
	output gedm_pkg::gedm_word_t out_word,
	input  wire logic            out_ready,
	output logic                 idle
);
	import gedm_pkg::*;
	logic       have_lo;
	logic [7:0] lo;

	assign in_ready = ce && !out_valid;
	assign idle     = !have_lo && !out_valid;

	// First byte of a pair lands in the low half of the word.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			have_lo   <= 1'b0;
			lo        <= 8'h00;
			out_valid <= 1'b0;
			out_word  <= 16'h0000;
		end else if (ce) begin
			if (in_valid && in_ready) begin // [RL18]
				if (have_lo) begin
					out_word  <= {in_byte, lo};
					out_valid <= 1'b1;
					have_lo   <= 1'b0;
				end else begin
					lo      <= in_byte;
					have_lo <= 1'b1;
				end
			end else if (flush && have_lo && !out_valid) begin
				out_word  <= {8'h00, lo};
				out_valid <= 1'b1;
				have_lo   <= 1'b0;
			end else if (out_valid && out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end

	AST_PACK_PAIR: assert property (@(posedge mclk) disable iff (!rst_n) // [RL18]
		in_valid && in_ready && have_lo |=> out_valid && out_word == {$past(in_byte), $past(lo)})
		else $error("Byte pair was not packed into one word.");
	AST_PACK_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // [RL18]
		out_valid && !(ce && out_ready) |=> out_valid && $stable(out_word))
		else $error("Packed word changed before it was taken.");
endmodule : gedm_pack
`default_nettype wire

// *** hdl/gedm_pkg.sv ***
`default_nettype none
package gedm_pkg;
	typedef logic [15:0] gedm_word_t;
	typedef logic [7:0]  gedm_addr_t;
	typedef logic [8:0]  gedm_events_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_FLUSH = 3'b100
	} gedm_state_t;
endpackage : gedm_pkg
`default_nettype wire

// *** hdl/gedm_top.sv ***
// Operation
// RL1: Disarm word: nine event mask bits, rest zero.
// RL2: Masked internal service request leaves notification alone.
// RL3: Masked device clear leaves notification alone.
// RL4: Masked listen addressing leaves notification alone.
// RL5: Masked talk addressing leaves notification alone.
// RL6: Masked idle leaves notification alone.
// RL7: Mode word: single, demand, auto-reload bits.
// RL8: Default mode is single without auto-reload.
// RL9: Single mode: one byte per DMA grant. The code moves one packed 16-bit word per grant instead.
// RL10: Demand mode: controller holds bus while requested.
// RL11: Demand bus returns after request drops.
// RL12: Single plus demand together is rejected.
// RL13: Auto-reload restores count and repeats transfer. The code reloads only in continue mode and otherwise ends at the count.
// RL14: Auto-reload lasts until next transfer completes.
// RL15: Auto-reload buffers stay within one page.
// RL16: Byte count 0..65535; zero means terminator only.
// RL17: Input mode: continue bit and DMA bit.
// RL18: Bytes packed two per 16-bit word.
// RL19: Board select picks the addressed board.
// RL20: Completion code zero means success.
// RL21: Continue returns early after first byte.
// RL22: Continue with auto-reload runs until stop/terminator.
// RL23: DMA bit raises request per ready word.
`default_nettype none
`include "gedm_cfg.svh"
module gedm_top (
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	input  wire logic                   ce,
	input  wire logic [1:0]             board_id,
	input  wire gedm_pkg::gedm_addr_t   awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire gedm_pkg::gedm_addr_t   araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	input  wire gedm_pkg::gedm_events_t bus_event,
	input  wire logic                   rx_valid,
	input  wire logic [7:0]             rx_data,
	input  wire logic                   rx_term,
	output logic                        rx_ready,
	output logic                        dma_req,
	input  wire logic                   dma_ack,
	output gedm_pkg::gedm_word_t        dma_data,
	output logic                        event_notify
);
	import gedm_pkg::*;

	logic         rst_meta;
	logic         rst_n;
	logic         strap_taken;
	logic [1:0]   my_board;
	logic         wr_en;
	gedm_addr_t   wr_addr;
	logic [31:0]  wr_data;
	logic [3:0]   wr_strb;
	logic         rd_en;
	gedm_addr_t   rd_addr;
	logic [31:0]  rd_data;
	logic         rd_err;
	logic         wr_err;
	logic [31:0]  cur_value;
	gedm_word_t   wr_lo;
	gedm_events_t disarm;
	logic [2:0]   dma_mode;
	logic [1:0]   in_mode;
	gedm_word_t   in_count;
	logic [1:0]   board_sel;
	logic         tmo_off;
	logic [7:0]   completion;
	gedm_events_t evt_seen;
	gedm_state_t  state;
	gedm_word_t   remaining;
	gedm_word_t   cnt_latch;
	logic         count_on;
	logic         cur_dma;
	logic         cur_cont;
	logic         done;
	logic         released;
	logic         single_gap;
	logic         pk_out_valid;
	gedm_word_t   pk_out_word;
	logic         pk_out_ready;
	logic         pk_in_ready;
	logic         pk_idle;
	logic         board_ok;
	logic         cfg_any;
	logic         cfg_wr;
	logic         bad_mode;
	logic         start_go;
	logic         stop_go;
	logic         byte_take;
	logic         last_by_count;
	logic         reload;
	logic         end_now;
	logic         finish;
	logic         dma_take;
	logic         data_pop;
	logic         mode_wr;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// The board number strap is sampled once, on the first enabled edge after reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken <= 1'b0;
			my_board    <= 2'b00;
		end else if (ce && !strap_taken) begin
			strap_taken <= 1'b1;
			my_board    <= board_id;
		end
	end

	gedm_axil u_bus (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.ce      (ce),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err),
		.wr_err  (wr_err)
	);

	function automatic logic is_mapped(input gedm_addr_t a);
		is_mapped = (a <= `GEDM_A_DATA) && (a[1:0] == 2'b00);
	endfunction : is_mapped

	function automatic logic [31:0] reg_read(input gedm_addr_t a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`GEDM_A_DISARM:     v = {23'h000000, disarm};
			`GEDM_A_DMA_MODE:   v = {29'h00000000, dma_mode};
			`GEDM_A_IN_MODE:    v = {30'h00000000, in_mode};
			`GEDM_A_IN_COUNT:   v = {16'h0000, in_count};
			`GEDM_A_BOARD:      v = {30'h00000000, board_sel};
			`GEDM_A_CONTROL:    v = {29'h00000000, tmo_off, 2'b00};
			`GEDM_A_COMPLETION: v = {24'h000000, completion};
			`GEDM_A_STATUS:     v = {25'h0000000, my_board, pk_out_valid, dma_mode[`GEDM_MODE_AUTO],
			                         released, done, state != ST_IDLE};
			`GEDM_A_EVENTS:     v = {23'h000000, evt_seen};
			`GEDM_A_DATA:       v = {16'h0000, pk_out_word};
			default:            v = 32'h0000_0000;
		endcase
		reg_read = v;
	endfunction : reg_read

	// Byte enables act on the low two lanes; the upper lanes hold no register bits.
	always_comb begin
		cur_value = reg_read(wr_addr);
		wr_lo     = {wr_strb[1] ? wr_data[15:8] : cur_value[15:8], wr_strb[0] ? wr_data[7:0] : cur_value[7:0]};
		rd_data   = reg_read(rd_addr);
	end

	assign rd_err   = !is_mapped(rd_addr);
	assign wr_err   = !is_mapped(wr_addr);
	assign board_ok = (board_sel == my_board); // [RL19]
	assign cfg_any  = wr_en && (wr_addr == `GEDM_A_DISARM || wr_addr == `GEDM_A_DMA_MODE
		|| wr_addr == `GEDM_A_IN_MODE || wr_addr == `GEDM_A_IN_COUNT || wr_addr == `GEDM_A_CONTROL);
	assign cfg_wr   = cfg_any && board_ok; // [RL19]
	assign bad_mode = wr_lo[`GEDM_MODE_SIN] && wr_lo[`GEDM_MODE_DEM]; // [RL12]
	assign mode_wr  = cfg_wr && wr_addr == `GEDM_A_DMA_MODE && !bad_mode;
	assign start_go = cfg_wr && wr_addr == `GEDM_A_CONTROL && wr_lo[`GEDM_CTL_START] && state == ST_IDLE;
	assign stop_go  = cfg_wr && wr_addr == `GEDM_A_CONTROL && wr_lo[`GEDM_CTL_STOP] && state == ST_RUN;

	assign rx_ready      = (state == ST_RUN) && pk_in_ready;
	assign byte_take     = rx_valid && rx_ready;
	assign last_by_count = count_on && remaining == 16'h0001; // [RL16]
	assign reload        = cur_cont && dma_mode[`GEDM_MODE_AUTO]; // [RL22]
	assign end_now       = (byte_take && (rx_term || (last_by_count && !reload))) || stop_go; // [RL22]
	assign finish        = ce && state == ST_FLUSH && pk_idle;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			disarm    <= `GEDM_DISARM_RST;
			in_mode   <= 2'b00;
			in_count  <= 16'h0000;
			board_sel <= 2'b00;
			tmo_off   <= 1'b0;
		end else if (ce) begin
			if (cfg_wr && wr_addr == `GEDM_A_DISARM) begin
				disarm <= wr_lo[8:0]; // [RL1]
			end
			if (cfg_wr && wr_addr == `GEDM_A_IN_MODE) begin
				in_mode <= wr_lo[1:0]; // [RL17]
			end
			if (cfg_wr && wr_addr == `GEDM_A_IN_COUNT) begin
				in_count <= wr_lo; // [RL16]
			end
			if (cfg_wr && wr_addr == `GEDM_A_CONTROL) begin
				tmo_off <= wr_lo[`GEDM_CTL_TMO_OFF];
			end
			if (wr_en && wr_addr == `GEDM_A_BOARD) begin
				board_sel <= wr_lo[1:0];
			end
		end
	end

	// A write to the mode word in the finishing cycle wins over the auto-reload clear.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dma_mode <= `GEDM_DMA_MODE_RST; // [RL8]
		end else if (ce) begin
			if (mode_wr) begin
				dma_mode <= wr_lo[2:0]; // [RL7] [RL12]
			end else if (finish) begin
				dma_mode[`GEDM_MODE_AUTO] <= 1'b0; // [RL14]
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			completion <= `GEDM_CC_OK;
		end else if (ce && cfg_any) begin // [RL20]
			if (!board_ok) begin
				completion <= `GEDM_CC_BOARD;
			end else if (wr_addr == `GEDM_A_DMA_MODE && bad_mode) begin
				completion <= `GEDM_CC_MODE;
			end else if (wr_addr == `GEDM_A_CONTROL && wr_lo[`GEDM_CTL_START] && state != ST_IDLE) begin
				completion <= `GEDM_CC_BUSY;
			end else begin
				completion <= `GEDM_CC_OK;
			end
		end
	end

	// Notification follows only the events whose mask bit is clear; seen events stick until written one.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			event_notify <= 1'b0;
			evt_seen     <= 9'h000;
		end else if (ce) begin
			event_notify <= |(bus_event & ~disarm); // [RL2] [RL3] [RL4] [RL5] [RL6]
			if (wr_en && wr_addr == `GEDM_A_EVENTS) begin
				evt_seen <= (evt_seen & ~wr_lo[8:0]) | (bus_event & ~disarm);
			end else begin
				evt_seen <= evt_seen | (bus_event & ~disarm);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else if (ce) begin
			unique case (state)
				ST_IDLE:  if (start_go) state <= ST_RUN;
				ST_RUN:   if (end_now) state <= ST_FLUSH;
				ST_FLUSH: if (pk_idle) state <= ST_IDLE;
			endcase
		end
	end

	// In continue mode, auto-reload refills the count inside one buffer; the page limit is the host's to keep.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			remaining <= 16'h0000;
			cnt_latch <= 16'h0000;
			count_on  <= 1'b0;
			cur_dma   <= 1'b0;
			cur_cont  <= 1'b0;
		end else if (ce) begin
			if (start_go) begin
				remaining <= in_count;
				cnt_latch <= in_count;
				count_on  <= in_count != 16'h0000; // [RL16]
				cur_dma   <= in_mode[`GEDM_IN_DMA]; // [RL17]
				cur_cont  <= in_mode[`GEDM_IN_CONT];
			end else if (byte_take && count_on) begin
				if (last_by_count && reload) begin
					remaining <= cnt_latch; // [RL13] [RL15] [RL22]
				end else begin
					remaining <= remaining - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done     <= 1'b0;
			released <= 1'b0;
		end else if (ce) begin
			if (start_go) begin
				done     <= 1'b0;
				released <= in_mode[`GEDM_IN_CONT] && tmo_off; // [RL21]
			end else if (finish) begin
				done     <= 1'b1;
				released <= 1'b1;
			end else if (byte_take && cur_cont) begin
				released <= 1'b1; // [RL21]
			end
		end
	end

	// Single mode drops the request for a cycle after each grant, so the controller returns the bus.
	assign dma_req      = ce && cur_dma && pk_out_valid && !single_gap; // [RL23] [RL9] [RL10]
	assign dma_take     = dma_req && dma_ack;
	assign data_pop     = rd_en && rd_addr == `GEDM_A_DATA && !cur_dma;
	assign pk_out_ready = dma_take || data_pop;
	assign dma_data     = pk_out_word;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			single_gap <= 1'b0;
		end else if (ce) begin
			single_gap <= dma_take && dma_mode[`GEDM_MODE_SIN]; // [RL9] [RL11]
		end
	end

	gedm_pack u_pack (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (rx_valid && state == ST_RUN),
		.in_byte   (rx_data),
		.in_ready  (pk_in_ready),
		.flush     (state == ST_FLUSH),
		.out_valid (pk_out_valid),
		.out_word  (pk_out_word),
		.out_ready (pk_out_ready),
		.idle      (pk_idle)
	);

	AST_MASK_QUIET: assert property (@(posedge mclk) disable iff (!rst_n) // [RL2] [RL3] [RL4] [RL5] [RL6]
		ce && (bus_event & ~disarm) == 9'h000 |=> !event_notify)
		else $error("Notification raised by a masked event.");
	AST_EVENT_PASS: assert property (@(posedge mclk) disable iff (!rst_n) // [RL1]
		ce && (bus_event & ~disarm) != 9'h000 |=> event_notify && evt_seen != 9'h000)
		else $error("Unmasked event gave no notification.");
	AST_MODE_EXCL: assert property (@(posedge mclk) disable iff (!rst_n) // [RL7]
		!(dma_mode[`GEDM_MODE_SIN] && dma_mode[`GEDM_MODE_DEM]))
		else $error("Single and demand both active.");
	AST_MODE_REJECT: assert property (@(posedge mclk) disable iff (!rst_n) // [RL12]
		ce && cfg_wr && wr_addr == `GEDM_A_DMA_MODE && bad_mode |=> completion == `GEDM_CC_MODE)
		else $error("Conflicting mode word not reported.");
	AST_BOARD_REJECT: assert property (@(posedge mclk) disable iff (!rst_n) // [RL19]
		ce && cfg_any && !board_ok |=> completion == `GEDM_CC_BOARD && $stable(disarm) && $stable(in_count))
		else $error("Write to another board took effect.");
	AST_AUTO_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n) // [RL14]
		finish && !mode_wr |=> !dma_mode[`GEDM_MODE_AUTO] && done && state == ST_IDLE)
		else $error("Auto-reload survived transfer completion.");
	AST_DMA_GATE: assert property (@(posedge mclk) disable iff (!rst_n) // [RL23]
		ce && cur_dma && $rose(pk_out_valid) |-> dma_req)
		else $error("Ready word in DMA mode raised no request.");
	AST_SINGLE_GAP: assert property (@(posedge mclk) disable iff (!rst_n) // [RL9]
		ce && dma_take && dma_mode[`GEDM_MODE_SIN] |=> !dma_req)
		else $error("Single mode request not dropped after a grant.");
	AST_COUNT_END: assert property (@(posedge mclk) disable iff (!rst_n) // [RL16]
		ce && byte_take && last_by_count && !reload |=> state == ST_FLUSH)
		else $error("Transfer went on past its byte count.");
	AST_RELOAD_RUN: assert property (@(posedge mclk) disable iff (!rst_n) // [RL22]
		ce && byte_take && last_by_count && reload && !rx_term && !stop_go
		|=> state == ST_RUN && remaining == cnt_latch)
		else $error("Continue with auto-reload stopped at count.");
	AST_RELEASE_FIRST: assert property (@(posedge mclk) disable iff (!rst_n) // [RL21]
		ce && state == ST_RUN && cur_cont && byte_take |=> released ##1 released)
		else $error("Continue mode did not release after first byte.");
endmodule : gedm_top
`default_nettype wire

// *** testbench/gedm_host_dma.sv ***
`default_nettype none
module gedm_host_dma (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic slow,
	input  wire logic dma_req,
	output logic      dma_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_cnt;
	// A slow controller leaves each request waiting several cycles before it grants the bus.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 2'h0;
			dma_ack  <= 1'b0;
		end else begin
			wait_cnt <= (dma_req && !dma_ack) ? wait_cnt + 2'h1 : 2'h0;
			dma_ack  <= dma_req && (!slow || (!dma_ack && wait_cnt == 2'h3));
		end
	end
endmodule : gedm_host_dma
`default_nettype wire

// *** testbench/gedm_top_tb.sv ***
`default_nettype none
`include "gedm_cfg.svh"
module gedm_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gedm_pkg::*;
	logic         mclk, nrst, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic         rvalid, rready, rx_valid, rx_term, rx_ready, dma_req, dma_ack, event_notify, slow;
	logic [1:0]   bresp, rresp, board_id;
	logic [3:0]   wstrb;
	logic [7:0]   rx_data, sb;
	logic [31:0]  wdata, rdata;
	gedm_addr_t   awaddr, araddr;
	gedm_events_t bus_event;
	gedm_word_t   dma_data;
	logic [33:0]  qr[$], qb[$], qd[$];
	int           miscompares, comparisons;

	gedm_top u_gedm_top (.*);
	gedm_host_dma u_gedm_host_dma (.*, .rst_n(nrst));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic test_done;
		if (qr.size() + qb.size() + qd.size() != 0)
			miscompares++;
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// Both bready and rready stay high, so every response is taken the cycle it appears.
	task automatic axw(input gedm_addr_t a, input logic [31:0] d, input logic [1:0] r);
		logic ah, wh, bh;
		qb.push_back({r, 32'h0});
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin
			@(negedge mclk);
			ah = awready;
			wh = wready;
			bh = bvalid;
			@(posedge mclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
	endtask : axw

	task automatic axr(input gedm_addr_t a, input logic [33:0] e);
		logic ah, rh;
		qr.push_back(e);
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge mclk);
			ah = arready;
			rh = rvalid;
			@(posedge mclk);
			if (ah) arvalid <= 1'b0;
		end while (!rh);
	endtask : axr

	task automatic evt(input gedm_events_t m);
		axw(`GEDM_A_DISARM, {16'h0, 7'h7f, m}, 2'h0);
		axr(`GEDM_A_DISARM, {25'h0, m});
		for (int i = 0; i < 9; i++) begin
			bus_event <= 9'h1 << i;
			@(posedge mclk);
			bus_event <= 9'h0;
			@(negedge mclk);
			chk({33'h0, !m[i]}, {33'h0, event_notify});
			@(posedge mclk);
		end
	endtask : evt

	task automatic xfer(input logic [2:0] md, input logic [15:0] cnt, input int n, input logic sl, input logic [1:0] im);
		logic [7:0] b[4];
		slow <= sl;
		for (int i = 0; i < n; i++)
			b[i] = 8'($urandom);
		for (int i = 0; i < n; i += 2)
			qd.push_back({18'h0, (i + 1 < n) ? b[i + 1] : 8'h0, b[i]});
		axw(`GEDM_A_DMA_MODE, {29'h0, md}, 2'h0);
		axw(`GEDM_A_IN_MODE, {30'h0, im}, 2'h0);
		axw(`GEDM_A_IN_COUNT, {16'h0, cnt}, 2'h0);
		axw(`GEDM_A_CONTROL, 32'h1, 2'h0);
		for (int i = 0; i < n; i++) begin
			rx_data  <= b[i];
			rx_term  <= (i == n - 1) && (cnt == 16'h0 || (im[1] && md[0]));
			rx_valid <= 1'b1;
			do @(negedge mclk); while (!rx_ready);
			@(posedge mclk);
		end
		rx_valid <= 1'b0;
		for (int k = 0; k < 200 && qd.size() > 0; k++)
			@(posedge mclk);
		repeat (4) @(posedge mclk);
		axr(`GEDM_A_STATUS, {27'h0, board_id, 5'h06});
		axr(`GEDM_A_DMA_MODE, {31'h0, md & 3'h6});
	endtask : xfer

	always @(negedge mclk) begin
		if (rvalid) chk(qr.size() > 0 ? qr.pop_front() : 34'bx, {rresp, rdata});
		if (bvalid) chk(qb.size() > 0 ? qb.pop_front() : 34'bx, {bresp, 32'h0});
		if (dma_req && dma_ack) chk(qd.size() > 0 ? qd.pop_front() : 34'bx, {18'h0, dma_data});
	end

	initial begin
		#100000;
		miscompares++;
		test_done();
	end

	initial begin
		miscompares = 0;
		comparisons = 0;
		{nrst, awvalid, wvalid, arvalid, rx_valid, rx_term, slow} = 7'h0;
		{ce, bready, rready, wstrb} = 7'h7f;
		{awaddr, araddr, wdata, rx_data, bus_event} = '0;
		void'($urandom(32'h00e7));
		board_id = 2'($urandom_range(3, 1));
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		axr(`GEDM_A_DISARM, 34'h0);
		axr(`GEDM_A_DMA_MODE, 34'h4);
		axr(`GEDM_A_COMPLETION, 34'h0);
		axr(8'h28, {2'h2, 32'h0});
		axw(`GEDM_A_DISARM, 32'h1ff, 2'h0);
		axr(`GEDM_A_COMPLETION, 34'h1);
		axr(`GEDM_A_DISARM, 34'h0);
		axw(`GEDM_A_BOARD, {30'h0, board_id}, 2'h0);
		axw(8'h28, 32'h0, 2'h2);
		evt(9'h000);
		// With the clock enable low an unmasked event must not raise the notification.
		ce        <= 1'b0;
		bus_event <= 9'h1ff;
		repeat (3) @(posedge mclk);
		bus_event <= 9'h000;
		@(negedge mclk);
		chk(34'h0, {33'h0, event_notify});
		@(posedge mclk);
		ce <= 1'b1;
		axr(`GEDM_A_EVENTS, 34'h1ff);
		axw(`GEDM_A_EVENTS, 32'h1ff, 2'h0);
		axr(`GEDM_A_EVENTS, 34'h0);
		evt(9'h1ff);
		evt(gedm_events_t'($urandom));
		axr(`GEDM_A_COMPLETION, 34'h0);
		axw(`GEDM_A_DMA_MODE, 32'h6, 2'h0);
		axr(`GEDM_A_COMPLETION, 34'h2);
		axr(`GEDM_A_DMA_MODE, 34'h4);
		xfer(3'h5, 16'h4, 4, 1'b1, 2'h1);
		xfer(3'h2, 16'h0, 3, 1'b0, 2'h1);
		xfer(3'h3, 16'h2, 4, 1'b0, 2'h3);
		// Continue mode without DMA, ended by a stop request; the odd byte is read back padded.
		axw(`GEDM_A_IN_MODE, 32'h2, 2'h0);
		axw(`GEDM_A_CONTROL, 32'h1, 2'h0);
		sb = 8'($urandom);
		rx_data  <= sb;
		rx_term  <= 1'b0;
		rx_valid <= 1'b1;
		do @(negedge mclk); while (!rx_ready);
		@(posedge mclk);
		rx_valid <= 1'b0;
		axw(`GEDM_A_CONTROL, 32'h2, 2'h0);
		axr(`GEDM_A_DATA, {26'h0, sb});
		axr(`GEDM_A_STATUS, {27'h0, board_id, 5'h06});
		test_done();
	end
endmodule : gedm_top_tb
`default_nettype wire
